// file: logic/tmc_top.sv
// Timer control and flag logic with its counter, reload and capture bytes.
// Assumes a processor core driving the register request in the system clock domain
// and a clock selector supplying the per-half clock codes.
`timescale 1ns/1ns
`include "tmc_map.svh"

module tmc_top
    import tmc_pkg::*;
#(
    parameter int DIV12 = `TMC_DIV12,
    parameter int TICK_CYC = `TMC_TICK_CYC,
    parameter int PULSE_CYC = `TMC_PULSE_CYC
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire tmc_sfr_req_t sfr_req_i,
    input wire logic [3:0] clk_sel_i,
    input wire logic [1:0] edge_sel_i,
    input wire logic ext_event_zero_i,
    output logic [7:0] sfr_rdata_o,
    output logic timer_irq_o
);
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] cnt_lo_reg;
    logic [7:0] cnt_hi_reg;
    logic [7:0] rld_lo_reg;
    logic [7:0] rld_hi_reg;
    logic [7:0] cnt_lo_next;
    logic [7:0] cnt_hi_next;
    logic [7:0] rld_lo_next;
    logic [7:0] rld_hi_next;
    logic [15:0] cnt16;
    logic [15:0] cnt16_inc;
    logic [3:0] ticks;
    logic lo_tick;
    logic hi_tick;
    logic cap_evt;
    logic hi_set;
    logic lo_set;
    logic sw_any;
    tmc_mode_t mode;

    // ============================================================
    // Decoding helpers
    function automatic logic pick_tick(input logic [3:0] t, input logic [1:0] sel);
        pick_tick = t[sel];
    endfunction : pick_tick

    // Byte write replaces the register; a bit access touches one bit of an
    // eight-aligned address only, so only the control register answers it.
    function automatic logic [7:0] sfr_merge(input logic [7:0] old,
                                             input tmc_sfr_req_t r,
                                             input logic [7:0] addr);
        logic [7:0] v;
        v = old;
        if (r.wr && r.addr == addr) begin
            v = r.wdata;
        end else if (r.bit_wr && addr[2:0] == 3'h0 && r.addr[7:3] == addr[7:3]) begin
            v[r.addr[2:0]] = r.bit_val;
        end
        sfr_merge = v;
    endfunction : sfr_merge

    // ============================================================
    // Clock selection and capture event
    tmc_tick_gen #(
        .DIV12(DIV12),
        .TICK_CYC(TICK_CYC),
        .PULSE_CYC(PULSE_CYC)
    ) u_tick (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .tick_o(ticks)
    );

    assign lo_tick = pick_tick(ticks, clk_sel_i[1:0]);
    assign hi_tick = pick_tick(ticks, clk_sel_i[3:2]);

    tmc_edge_det u_edge (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .ext_event_zero_i(ext_event_zero_i),
        .edge_sel_i(edge_sel_i),
        .event_o(cap_evt)
    );

    // ============================================================
    // Configuration decode
    always_comb begin
        if (ctrl_reg[`TMC_BIT_SPLIT]) begin
            mode = TMC_SPLIT;
        end else if (ctrl_reg[`TMC_BIT_LO_CAP]) begin
            mode = TMC_WIDE_CAPTURE;
        end else begin
            mode = TMC_WIDE_TIMER;
        end
    end

    assign cnt16 = {cnt_hi_reg, cnt_lo_reg};
    assign cnt16_inc = cnt16 + 16'h0001;
    assign sw_any = sfr_req_i.wr || sfr_req_i.bit_wr;

    // ============================================================
    // Counting, reload, capture and flag set conditions
    always_comb begin
        cnt_lo_next = cnt_lo_reg;
        cnt_hi_next = cnt_hi_reg;
        rld_lo_next = rld_lo_reg;
        rld_hi_next = rld_hi_reg;
        hi_set = 1'b0;
        lo_set = 1'b0;
        case (mode)
            TMC_WIDE_TIMER: begin
                // The high run bit is not consulted here: the low half owns the timer.
                if (ctrl_reg[`TMC_BIT_LO_RUN] && lo_tick) begin
                    {cnt_hi_next, cnt_lo_next} = cnt16_inc;
                    if (cnt16 == 16'hffff) begin
                        {cnt_hi_next, cnt_lo_next} = {rld_hi_reg, rld_lo_reg};
                        hi_set = 1'b1;
                    end
                    if (cnt_lo_reg == 8'hff) begin
                        lo_set = 1'b1;
                    end
                end
            end
            TMC_WIDE_CAPTURE: begin
                if (ctrl_reg[`TMC_BIT_LO_RUN] && lo_tick) begin
                    {cnt_hi_next, cnt_lo_next} = cnt16_inc;
                    if (cnt16 == 16'hffff) begin
                        lo_set = 1'b1;
                    end
                end
                // Capture does not depend on the run bit.
                if (cap_evt) begin
                    {rld_hi_next, rld_lo_next} = cnt16;
                    hi_set = 1'b1;
                end
            end
            TMC_SPLIT: begin
                if (ctrl_reg[`TMC_BIT_LO_RUN] && lo_tick) begin
                    cnt_lo_next = cnt_lo_reg + 8'h01;
                    if (cnt_lo_reg == 8'hff && !ctrl_reg[`TMC_BIT_LO_CAP]) begin
                        cnt_lo_next = rld_lo_reg;
                        lo_set = 1'b1;
                    end
                end
                if (ctrl_reg[`TMC_BIT_HI_RUN] && hi_tick) begin
                    cnt_hi_next = cnt_hi_reg + 8'h01;
                    if (cnt_hi_reg == 8'hff && !ctrl_reg[`TMC_BIT_HI_CAP]) begin
                        cnt_hi_next = rld_hi_reg;
                        hi_set = 1'b1;
                    end
                end
                if (cap_evt && ctrl_reg[`TMC_BIT_LO_CAP]) begin
                    rld_lo_next = cnt_lo_reg;
                    lo_set = 1'b1;
                end
                if (cap_evt && ctrl_reg[`TMC_BIT_HI_CAP]) begin
                    rld_hi_next = cnt_hi_reg;
                    hi_set = 1'b1;
                end
            end
            default: begin
            end
        endcase
    end

    // ============================================================
    // Control register: software merge, then hardware sets on top
    always_comb begin
        ctrl_next = sfr_merge(ctrl_reg, sfr_req_i, `TMC_ADDR_CTRL);
        ctrl_next[`TMC_BIT_HI_FLAG] = ctrl_next[`TMC_BIT_HI_FLAG] | hi_set;
        ctrl_next[`TMC_BIT_LO_FLAG] = ctrl_next[`TMC_BIT_LO_FLAG] | lo_set;
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_reg <= `TMC_RST_VAL;
        end else if (ce_i) begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ============================================================
    // Counter and reload bytes; a software write overrides the hardware update.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_lo_reg <= `TMC_RST_VAL;
            cnt_hi_reg <= `TMC_RST_VAL;
            rld_lo_reg <= `TMC_RST_VAL;
            rld_hi_reg <= `TMC_RST_VAL;
        end else if (ce_i) begin
            cnt_lo_reg <= sfr_merge(cnt_lo_next, sfr_req_i, `TMC_ADDR_CNT_LO);
            cnt_hi_reg <= sfr_merge(cnt_hi_next, sfr_req_i, `TMC_ADDR_CNT_HI);
            rld_lo_reg <= sfr_merge(rld_lo_next, sfr_req_i, `TMC_ADDR_RLD_LO);
            rld_hi_reg <= sfr_merge(rld_hi_next, sfr_req_i, `TMC_ADDR_RLD_HI);
        end
    end

    // ============================================================
    // Read data and interrupt request, both registered
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (ce_i) begin
            case (sfr_req_i.addr)
                `TMC_ADDR_CTRL: sfr_rdata_o <= ctrl_reg;
                `TMC_ADDR_RLD_LO: sfr_rdata_o <= rld_lo_reg;
                `TMC_ADDR_RLD_HI: sfr_rdata_o <= rld_hi_reg;
                `TMC_ADDR_CNT_LO: sfr_rdata_o <= cnt_lo_reg;
                `TMC_ADDR_CNT_HI: sfr_rdata_o <= cnt_hi_reg;
                default: sfr_rdata_o <= 8'h00;
            endcase
        end
    end

    // The request lags the flags by one cycle so the output stays a clean flop.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            timer_irq_o <= 1'b0;
        end else if (ce_i) begin
            timer_irq_o <= ctrl_reg[`TMC_BIT_HI_FLAG] |
                (ctrl_reg[`TMC_BIT_LO_FLAG] & ctrl_reg[`TMC_BIT_LO_EN]);
        end
    end

    // ============================================================
    // Assertions
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    irq_formula_a: assert property (ce_i |=> timer_irq_o ==
        ($past(ctrl_reg[7]) | ($past(ctrl_reg[6]) & $past(ctrl_reg[5]))))
        else $error("interrupt request does not match flags");

    hi_sticky_a: assert property ($fell(ctrl_reg[`TMC_BIT_HI_FLAG]) |->
        $past(sw_any) && $past(ce_i))
        else $error("high flag cleared without software");

    lo_sticky_a: assert property ($fell(ctrl_reg[`TMC_BIT_LO_FLAG]) |->
        $past(sw_any) && $past(ce_i))
        else $error("low flag cleared without software");

    wide_reload_a: assert property (ce_i && !sw_any && mode == TMC_WIDE_TIMER &&
        ctrl_reg[0] && lo_tick && cnt16 == 16'hffff |=>
        cnt16 == {$past(rld_hi_reg), $past(rld_lo_reg)} && ctrl_reg[7])
        else $error("wide overflow did not reload");

    wide_lo_roll_a: assert property (ce_i && mode == TMC_WIDE_TIMER &&
        ctrl_reg[0] && lo_tick && cnt_lo_reg == 8'hff |=> ctrl_reg[6])
        else $error("low byte rollover did not set low flag");

    wide_capture_a: assert property (ce_i && !sw_any && mode == TMC_WIDE_CAPTURE &&
        cap_evt |=> {rld_hi_reg, rld_lo_reg} == $past(cnt16) && ctrl_reg[7])
        else $error("wide capture did not latch counter");

    wide_cap_ovf_a: assert property (ce_i && !sw_any && mode == TMC_WIDE_CAPTURE &&
        ctrl_reg[0] && lo_tick && cnt16 == 16'hffff |=> ctrl_reg[6] && cnt16 == 16'h0000)
        else $error("wide capture overflow missed");

    split_hi_a: assert property (ce_i && !sw_any && mode == TMC_SPLIT &&
        !ctrl_reg[3] && ctrl_reg[1] && hi_tick && cnt_hi_reg == 8'hff |=>
        cnt_hi_reg == $past(rld_hi_reg) && ctrl_reg[7])
        else $error("split high overflow wrong");

    wide_stop_a: assert property (ce_i && !sw_any && !ctrl_reg[4] &&
        !ctrl_reg[0] |=> $stable(cnt16))
        else $error("wide counter moved without low run");

    set_wins_a: assert property (ce_i && (hi_set || lo_set) |=>
        (ctrl_reg[7] || !$past(hi_set)) && (ctrl_reg[6] || !$past(lo_set)))
        else $error("hardware set lost against clear");

    wide_reload_c: cover property (mode == TMC_WIDE_TIMER && hi_set);
    wide_capture_c: cover property (mode == TMC_WIDE_CAPTURE && cap_evt);
    split_both_c: cover property (mode == TMC_SPLIT && hi_set && lo_set);
    irq_seen_c: cover property (!timer_irq_o ##1 timer_irq_o);

endmodule : tmc_top

// file: logic/tmc_map.svh
// Address map, field positions, reset values and timing counts of the timer control block.
// Assumes a 20 MHz system clock; the counts below are derived from that period.
`ifndef TMC_MAP_SVH
`define TMC_MAP_SVH

// ============================================================
// Register addresses
`define TMC_ADDR_CTRL 8'hc8
`define TMC_ADDR_RLD_LO 8'hca
`define TMC_ADDR_RLD_HI 8'hcb
`define TMC_ADDR_CNT_LO 8'hcc
`define TMC_ADDR_CNT_HI 8'hcd

// ============================================================
// Control register fields
`define TMC_BIT_HI_FLAG 7
`define TMC_BIT_LO_FLAG 6
`define TMC_BIT_LO_EN 5
`define TMC_BIT_SPLIT 4
`define TMC_BIT_HI_CAP 3
`define TMC_BIT_LO_CAP 2
`define TMC_BIT_HI_RUN 1
`define TMC_BIT_LO_RUN 0
`define TMC_RST_VAL 8'h00

// ============================================================
// Timing
`define TMC_CLK_NS 50
`define TMC_DIV12 12
`define TMC_TICK_NS 5330
`define TMC_PULSE_NS 100000
`define TMC_TICK_CYC (`TMC_TICK_NS / `TMC_CLK_NS)
`define TMC_PULSE_CYC (`TMC_PULSE_NS / `TMC_CLK_NS)

`endif

// file: logic/tmc_pkg.sv
// Types shared by the timer control block.
// Assumes the constants of tmc_map.svh for numeric values.
package tmc_pkg;

    // ============================================================
    // Special function register request
    typedef struct packed {
        logic wr;
        logic bit_wr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic bit_val;
    } tmc_sfr_req_t;

    // ============================================================
    // Operating configuration
    typedef enum logic [1:0] {
        TMC_WIDE_TIMER,
        TMC_WIDE_CAPTURE,
        TMC_SPLIT
    } tmc_mode_t;

endpackage : tmc_pkg

// file: logic/tmc_tick_gen.sv
// Counting-clock tick generator: system clock, divide by twelve, short tick, long pulse.
// Assumes one system clock; ticks are one-cycle enables in that domain.
`timescale 1ns/1ns
`include "tmc_map.svh"
module tmc_tick_gen #(
    parameter int DIV12 = `TMC_DIV12,
    parameter int TICK_CYC = `TMC_TICK_CYC,
    parameter int PULSE_CYC = `TMC_PULSE_CYC
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    output logic [3:0] tick_o
);
    localparam int DIVS [3] = '{DIV12, TICK_CYC, PULSE_CYC};

    if (DIV12 < 2 || TICK_CYC < 2 || PULSE_CYC < 2) begin : g_bad
        $error("tmc_tick_gen: every divider must be at least two");
    end

    assign tick_o[0] = ce_i;

    // ============================================================
    // One free-running divider per slow tick
    for (genvar g = 0; g < 3; g++) begin : g_div
        localparam int W = $clog2(DIVS[g]);
        logic [W-1:0] div_reg;
        always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                div_reg <= '0;
            end else if (ce_i) begin
                if (div_reg == W'(DIVS[g] - 1)) begin
                    div_reg <= '0;
                end else begin
                    div_reg <= div_reg + W'(1);
                end
            end
        end
        assign tick_o[g+1] = ce_i && (div_reg == W'(DIVS[g] - 1));
    end

endmodule : tmc_tick_gen

// file: logic/tmc_edge_det.sv
// Capture event detector on the external event pin.
// Assumes the pin is asynchronous; it passes two flip-flops before the edge logic.
`timescale 1ns/1ns
module tmc_edge_det (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic ext_event_zero_i,
    input wire logic [1:0] edge_sel_i,
    output logic event_o
);
    logic sync1_reg;
    logic sync2_reg;
    logic last_reg;

    // ============================================================
    // Synchroniser and edge memory
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            last_reg <= 1'b0;
        end else if (ce_i) begin
            sync1_reg <= ext_event_zero_i;
            sync2_reg <= sync1_reg;
            last_reg <= sync2_reg;
        end
    end

    // Bit 0 selects rising edges, bit 1 falling edges; both give either edge.
    assign event_o = ce_i && ((edge_sel_i[0] && sync2_reg && !last_reg) ||
                              (edge_sel_i[1] && !sync2_reg && last_reg));

endmodule : tmc_edge_det

// file: tb/tmc_cpu_model.sv
// Processor core model that issues byte writes, bit writes and reads to the timer block.
// Assumes the block takes a request at the rising edge of ref_clk_i and answers a cycle later.
`timescale 1ns/1ns
module tmc_cpu_model
    import tmc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic [7:0] sfr_rdata_i,
    output tmc_sfr_req_t sfr_req_o
);
    initial sfr_req_o = '0;

    // ============================================================
    // Bus cycles
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        sfr_req_o.addr = a;
        sfr_req_o.wdata = d;
        sfr_req_o.wr = 1'b1;
        @(posedge ref_clk_i);
        #1;
        sfr_req_o.wr = 1'b0;
        // The released data bus must not keep showing the written value.
        sfr_req_o.wdata = ~d;
    endtask : wr_byte

    // Flags are cleared only by software: here one bit at a time, or by a control byte write.
    task automatic wr_bit(input logic [2:0] n, input logic v);
        @(posedge ref_clk_i);
        #1;
        sfr_req_o.addr = 8'hc8 | {5'h00, n};
        sfr_req_o.bit_val = v;
        sfr_req_o.bit_wr = 1'b1;
        @(posedge ref_clk_i);
        #1;
        sfr_req_o.bit_wr = 1'b0;
        sfr_req_o.bit_val = ~v;
    endtask : wr_bit

    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        sfr_req_o.addr = a;
        @(posedge ref_clk_i);
        #1;
        d = sfr_rdata_i;
    endtask : rd_byte
endmodule : tmc_cpu_model

// file: tb/tb.sv
// Self-checking bench for the timer control block with a core model on its register bus.
// Assumes short tick divider parameters so that every clock code is seen in a short run.
`timescale 1ns/1ns
module tb
    import tmc_pkg::*;
();
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [3:0] clk_sel_i = 4'h0;
    logic [1:0] edge_sel_i = 2'h0;
    logic ext_event_zero_i = 1'b0;
    tmc_sfr_req_t sfr_req_i;
    logic [7:0] sfr_rdata_o;
    logic timer_irq_o;
    int errors = 0;
    int cmp_count = 0;

    always #25 ref_clk_i = ~ref_clk_i;

    tmc_cpu_model u_tmc_cpu_model (
        .ref_clk_i(ref_clk_i),
        .sfr_rdata_i(sfr_rdata_o),
        .sfr_req_o(sfr_req_i)
    );

    tmc_top #(.DIV12(3), .TICK_CYC(4), .PULSE_CYC(5)) u_tmc_top (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .sfr_req_i(sfr_req_i),
        .clk_sel_i(clk_sel_i),
        .edge_sel_i(edge_sel_i),
        .ext_event_zero_i(ext_event_zero_i),
        .sfr_rdata_o(sfr_rdata_o),
        .timer_irq_o(timer_irq_o)
    );

    // ============================================================
    // Shared helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_tmc_cpu_model.wr_byte(a, d);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_tmc_cpu_model.rd_byte(a, d);
        check(d, exp);
    endtask : rd_chk

    // The request output is registered, so it trails the flags by one cycle.
    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge ref_clk_i);
        #1;
        check({7'h00, timer_irq_o}, {7'h00, exp});
    endtask : irq_chk

    // Six cycles cover the two synchroniser stages and the edge logic.
    task automatic pin(input logic v);
        @(posedge ref_clk_i);
        #1;
        ext_event_zero_i = v;
        repeat (6) @(posedge ref_clk_i);
    endtask : pin

    // ============================================================
    // Scenarios
    task automatic t_reset();
        rd_chk(8'hc8, 8'h00);
        rd_chk(8'hcc, 8'h00);
        rd_chk(8'hcb, 8'h00);
        rd_chk(8'hc9, 8'h00);
        wr(8'hc8, 8'h3c);
        rd_chk(8'hc8, 8'h3c);
        wr(8'hc8, 8'h00);
        u_tmc_cpu_model.wr_bit(3'd7, 1'b1);
        rd_chk(8'hc8, 8'h80);
        irq_chk(1'b1);
        u_tmc_cpu_model.wr_bit(3'd7, 1'b0);
        rd_chk(8'hc8, 8'h00);
        $display("test reset_access done");
    endtask : t_reset

    task automatic t_irq();
        wr(8'hc8, 8'h40);
        irq_chk(1'b0);
        wr(8'hc8, 8'h60);
        irq_chk(1'b1);
        wr(8'hc8, 8'h20);
        irq_chk(1'b0);
        $display("test irq_combine done");
    endtask : t_irq

    task automatic t_wide();
        wr(8'hc8, 8'h00);
        wr(8'hca, 8'hf0);
        wr(8'hcb, 8'hff);
        wr(8'hcc, 8'hfe);
        wr(8'hcd, 8'hff);
        wr(8'hc8, 8'h02);
        repeat (10) @(posedge ref_clk_i);
        rd_chk(8'hcc, 8'hfe);
        wr(8'hc8, 8'h01);
        repeat (3) @(posedge ref_clk_i);
        rd_chk(8'hc8, 8'hc1);
        rd_chk(8'hcd, 8'hff);
        wr(8'hc8, 8'h00);
        wr(8'hcc, 8'hfe);
        wr(8'hcd, 8'h00);
        wr(8'hc8, 8'h01);
        repeat (3) @(posedge ref_clk_i);
        rd_chk(8'hc8, 8'h41);
        $display("test wide_timer done");
    endtask : t_wide

    task automatic t_cap();
        wr(8'hc8, 8'h00);
        wr(8'hcc, 8'h34);
        wr(8'hcd, 8'h12);
        wr(8'hc8, 8'h04);
        edge_sel_i = 2'b01;
        pin(1'b1);
        rd_chk(8'hca, 8'h34);
        rd_chk(8'hcb, 8'h12);
        rd_chk(8'hc8, 8'h84);
        wr(8'hcc, 8'h78);
        pin(1'b0);
        rd_chk(8'hca, 8'h34);
        edge_sel_i = 2'b10;
        pin(1'b1);
        rd_chk(8'hca, 8'h34);
        pin(1'b0);
        rd_chk(8'hca, 8'h78);
        edge_sel_i = 2'b11;
        wr(8'hcc, 8'h9a);
        pin(1'b1);
        rd_chk(8'hca, 8'h9a);
        wr(8'hcc, 8'hbc);
        pin(1'b0);
        rd_chk(8'hca, 8'hbc);
        wr(8'hc8, 8'h04);
        wr(8'hcc, 8'hfe);
        wr(8'hcd, 8'hff);
        wr(8'hc8, 8'h05);
        repeat (3) @(posedge ref_clk_i);
        rd_chk(8'hc8, 8'h45);
        rd_chk(8'hcd, 8'h00);
        $display("test wide_capture done");
    endtask : t_cap

    task automatic t_split();
        wr(8'hc8, 8'h00);
        wr(8'hcb, 8'h80);
        wr(8'hcd, 8'hfe);
        wr(8'hcc, 8'h55);
        edge_sel_i = 2'b01;
        wr(8'hc8, 8'h16);
        repeat (4) @(posedge ref_clk_i);
        pin(1'b1);
        rd_chk(8'hca, 8'h55);
        rd_chk(8'hcb, 8'h80);
        rd_chk(8'hcc, 8'h55);
        rd_chk(8'hc8, 8'hd6);
        pin(1'b0);
        wr(8'hc8, 8'h1c);
        wr(8'hcd, 8'h3e);
        pin(1'b1);
        rd_chk(8'hcb, 8'h3e);
        rd_chk(8'hc8, 8'hdc);
        pin(1'b0);
        $display("test split done");
    endtask : t_split

    task automatic t_clk();
        int div [4] = '{1, 3, 4, 5};
        logic [7:0] d;
        wr(8'hc8, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(8'hcc, 8'h00);
            wr(8'hcd, 8'h00);
            clk_sel_i = {2'(c), 2'(c)};
            wr(8'hc8, 8'h13);
            repeat (60) @(posedge ref_clk_i);
            wr(8'hc8, 8'h10);
            u_tmc_cpu_model.rd_byte(8'hcc, d);
            check({7'h00, (d >= 8'(60 / div[c])) && (d <= 8'(63 / div[c] + 1))}, 8'h01);
            u_tmc_cpu_model.rd_byte(8'hcd, d);
            check({7'h00, (d >= 8'(60 / div[c])) && (d <= 8'(63 / div[c] + 1))}, 8'h01);
        end
        $display("test clock_codes done");
    endtask : t_clk

    // Ten frozen cycles must not count: only three enabled edges see the run bit.
    task automatic t_hold();
        wr(8'hcc, 8'h00);
        clk_sel_i = 4'h0;
        wr(8'hc8, 8'h11);
        @(posedge ref_clk_i);
        #1;
        ce_i = 1'b0;
        repeat (10) @(posedge ref_clk_i);
        #1;
        ce_i = 1'b1;
        wr(8'hc8, 8'h10);
        rd_chk(8'hcc, 8'h03);
        $display("test clock_enable done");
    endtask : t_hold

    // ============================================================
    // Verdict
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (20) @(posedge ref_clk_i);
        #1;
        sys_rst_i = 1'b0;
        t_reset();
        t_irq();
        t_wide();
        t_cap();
        t_split();
        t_clk();
        t_hold();
        close_out();
    end

    // The tests need well under a thousand cycles; this limit leaves wide margin.
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        errors++;
        $display("[FAIL] t=%0t watchdog expired", $time);
        close_out();
    end
endmodule : tb
